// >>> src/sadc_sequencer.sv
// Successive-approximation converter sequencer with AHB-Lite register slave
//
// Notes on behaviour
// - Channel select codes 0..6 route inputs zero to six; code 7 selects none.
// - Converting with channel code 7 returns full-scale result.
// - Go bit reads one while acquiring or converting, zero when idle.
// - Enable bit 0 of control register 0 turns converter on or off.
// - Pin config bit one means digital; zero means analog, digital input reads zero.
// - Nonzero acquisition code samples 2..20 bit periods after go, then converts.
// - Acquisition code zero converts as soon as go is set.
// - Clock select picks oscillator divide 2..64 or internal RC for x11.
// - Conversion takes 11 bit periods.
// - On completion load result, clear go, set done flag.
// - After completion sampling of the selected channel resumes.
// - Two bit periods wait after conversion before next acquisition.
// - Reset returns registers to reset values and aborts conversion.
// - Result pair is not initialised by reset.
// - Go stays set across acquisition and conversion with no phase indication.
// - Clearing go during conversion aborts and keeps the previous result.
// - With acquisition code zero, conversion start is delayed one hclk cycle.
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_sequencer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        comparator_in,
    input  wire logic [6:0]  pin_digital_in,
    output logic      [6:0]  pin_digital_value,
    output logic      [6:0]  pin_analog_mode,
    output logic      [6:0]  channel_route,
    output logic             sample_enable,
    output logic      [9:0]  dac_code,
    output logic             conversion_done_flag,
    output logic             converter_enable
);
    sadc_pkg::sadc_state_vec_t s_r;
    sadc_pkg::sadc_state_vec_t s_nxt;
    logic [9:0] result_r;
    logic       load_result;
    logic [9:0] final_code;
    logic [11:0] div_limit;
    logic [4:0]  acq_tads;
    logic        wr_phase;

    // Divider terminal count per clock select
    always_comb begin
        case (s_r.c2.clk)
            3'b000:  div_limit = 12'd1;
            3'b100:  div_limit = 12'd3;
            3'b001:  div_limit = 12'd7;
            3'b101:  div_limit = 12'd15;
            3'b010:  div_limit = 12'd31;
            3'b110:  div_limit = 12'd63;
            default: div_limit = 12'(`SADC_RC_DIV - 1);
        endcase
    end

    always_comb begin
        case (s_r.c2.acq)
            3'b001:  acq_tads = 5'd2;
            3'b010:  acq_tads = 5'd4;
            3'b011:  acq_tads = 5'd6;
            3'b100:  acq_tads = 5'd8;
            3'b101:  acq_tads = 5'd12;
            3'b110:  acq_tads = 5'd16;
            3'b111:  acq_tads = 5'd20;
            default: acq_tads = 5'd0;
        endcase
    end

    assign wr_phase = s_r.ap_valid && s_r.ap_write;

    always_comb begin
        s_nxt       = s_r;
        load_result = 1'b0;
        final_code  = s_r.sar;
        s_nxt.pin_meta = pin_digital_in;
        s_nxt.pin_sync = s_r.pin_meta;

        // Bit period enable pulse
        s_nxt.conversion_bit_period = 1'b0;
        if (!s_r.c0.en || s_r.st == sadc_pkg::SADC_IDLE) begin
            s_nxt.div = 12'd0;
        end else if (s_r.div >= div_limit) begin
            s_nxt.div = 12'd0;
            s_nxt.conversion_bit_period = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 12'd1;
        end

        // Register writes in data phase
        if (wr_phase) begin
            case (s_r.ap_addr)
                `SADC_OFF_CTRL0: begin
                    s_nxt.c0.en = hwdata[`SADC_BIT_ENABLE];
                    s_nxt.c0.ch = hwdata[4:2];
                    s_nxt.c0.go = hwdata[`SADC_BIT_GO] && hwdata[`SADC_BIT_ENABLE] && s_r.c0.en;
                end
                `SADC_OFF_PINCFG: s_nxt.pcfg = hwdata[6:0];
                `SADC_OFF_CTRL2: begin
                    s_nxt.c2.justify = hwdata[`SADC_BIT_JUSTIFY];
                    s_nxt.c2.acq     = hwdata[5:3];
                    s_nxt.c2.clk     = hwdata[2:0];
                end
                `SADC_OFF_FLAGS: s_nxt.done_flag = hwdata[0];
                default: ;
            endcase
        end

        case (s_r.st)
            sadc_pkg::SADC_IDLE: begin
                if (s_r.c0.go && s_r.c0.en) begin
                    s_nxt.tcnt = 5'd0;
                    s_nxt.sar  = 10'h200;
                    if (s_r.c2.acq == 3'b000) begin
                        s_nxt.delay = 1'b1;
                        s_nxt.st    = sadc_pkg::SADC_CONV;
                    end else begin
                        s_nxt.st = sadc_pkg::SADC_ACQ;
                    end
                end
            end
            sadc_pkg::SADC_ACQ: begin
                if (s_r.conversion_bit_period) begin
                    s_nxt.tcnt = s_r.tcnt + 5'd1;
                    if (s_r.tcnt + 5'd1 >= acq_tads) begin
                        s_nxt.tcnt = 5'd0;
                        s_nxt.st   = sadc_pkg::SADC_CONV;
                    end
                end
            end
            sadc_pkg::SADC_CONV: begin
                if (s_r.delay) begin
                    s_nxt.delay = 1'b0;
                    s_nxt.tcnt  = 5'd0;
                    s_nxt.div   = 12'd0;
                end else if (s_r.conversion_bit_period) begin
                    s_nxt.tcnt = s_r.tcnt + 5'd1;
                    // One bit per period, MSB first, first period settles
                    if (s_r.tcnt >= 5'd1 && s_r.tcnt <= 5'd10) begin
                        for (int i = 0; i < 10; i++) begin
                            if (5'(i + 1) == s_r.tcnt) begin
                                // Comparator follows dac_code on this clock; a synchroniser would go stale at 2 clocks
                                s_nxt.sar[9 - i] = comparator_in;
                                if (i < 9) begin
                                    s_nxt.sar[8 - i] = 1'b1;
                                end
                            end
                        end
                    end
                    if (s_r.tcnt + 5'd1 >= 5'({1'b0, `SADC_CONV_TADS})) begin
                        load_result     = 1'b1;
                        s_nxt.c0.go     = 1'b0;
                        s_nxt.done_flag = 1'b1;
                        s_nxt.tcnt      = 5'd0;
                        s_nxt.st        = sadc_pkg::SADC_GAP;
                    end
                end
                final_code = (s_r.c0.ch == 3'b111) ? `SADC_FULL_SCALE : s_nxt.sar;
            end
            sadc_pkg::SADC_GAP: begin
                if (s_r.conversion_bit_period) begin
                    s_nxt.tcnt = s_r.tcnt + 5'd1;
                    if (s_r.tcnt + 5'd1 >= 5'({1'b0, `SADC_GAP_TADS})) begin
                        s_nxt.tcnt = 5'd0;
                        s_nxt.st   = sadc_pkg::SADC_IDLE;
                    end
                end
            end
            default: s_nxt.st = sadc_pkg::SADC_IDLE;
        endcase

        // Software abort yields to completion in the same cycle, result untouched; disable always forces idle
        if ((!s_nxt.c0.go || !s_nxt.c0.en) && !load_result &&
            (s_r.st == sadc_pkg::SADC_ACQ || s_r.st == sadc_pkg::SADC_CONV)) begin
            s_nxt.c0.go = 1'b0;
            s_nxt.tcnt  = 5'd0;
            s_nxt.delay = 1'b0;
            s_nxt.st    = s_nxt.c0.en ? sadc_pkg::SADC_GAP : sadc_pkg::SADC_IDLE;
        end
        if (!s_nxt.c0.en) begin
            s_nxt.st = sadc_pkg::SADC_IDLE;
            s_nxt.c0.go = 1'b0;
        end
        // Hardware set wins over software clear
        if (load_result) begin
            s_nxt.done_flag = 1'b1;
        end

        // Address phase capture
        if (hready) begin
            s_nxt.ap_valid = hsel && htrans[1];
            s_nxt.ap_write = hwrite;
            s_nxt.ap_addr  = haddr[7:0];
        end else begin
            s_nxt.ap_valid = 1'b0;
        end
        if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                `SADC_OFF_CTRL0:  s_nxt.rdata = {27'h0, s_nxt.c0.ch, s_nxt.c0.go, s_nxt.c0.en};
                `SADC_OFF_PINCFG: s_nxt.rdata = {25'h0, s_nxt.pcfg};
                `SADC_OFF_CTRL2:  s_nxt.rdata = {24'h0, s_nxt.c2.justify, 1'b0, s_nxt.c2.acq, s_nxt.c2.clk};
                `SADC_OFF_RESH:   s_nxt.rdata = s_r.c2.justify ? {30'h0, result_r[9:8]}
                                                               : {24'h0, result_r[9:2]};
                `SADC_OFF_RESL:   s_nxt.rdata = s_r.c2.justify ? {24'h0, result_r[7:0]}
                                                               : {24'h0, result_r[1:0], 6'h00};
                `SADC_OFF_FLAGS:  s_nxt.rdata = {31'h0, s_nxt.done_flag};
                default:          s_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{st: sadc_pkg::SADC_IDLE, c0: 5'(`SADC_CTRL0_RESET), pcfg: 7'(`SADC_PINCFG_RESET),
                     c2: 7'(`SADC_CTRL2_RESET), default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Result pair holds across reset, loaded only on completion
    always_ff @(posedge hclk) begin
        if (load_result) begin
            result_r <= final_code;
        end
    end

    always_comb begin
        channel_route = 7'h00;
        if (s_r.c0.en && s_r.c0.ch != 3'b111) begin
            channel_route[s_r.c0.ch] = 1'b1;
        end
    end

    assign hrdata               = s_r.rdata;
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign pin_analog_mode      = ~s_r.pcfg;
    assign pin_digital_value    = s_r.pin_sync & s_r.pcfg;
    assign sample_enable        = s_r.c0.en && (s_r.st == sadc_pkg::SADC_IDLE || s_r.st == sadc_pkg::SADC_ACQ);
    assign dac_code             = s_r.sar;
    assign conversion_done_flag = s_r.done_flag;
    assign converter_enable     = s_r.c0.en;
endmodule

// >>> shared/sadc_consts.svh
// Register offsets, field positions, reset values and timing counts for the converter sequencer
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
`define SADC_OFF_CTRL0      8'h00
`define SADC_OFF_PINCFG     8'h04
`define SADC_OFF_CTRL2      8'h08
`define SADC_OFF_RESH       8'h0c
`define SADC_OFF_RESL       8'h10
`define SADC_OFF_FLAGS      8'h14
`define SADC_CTRL0_RESET    8'h00
`define SADC_PINCFG_RESET   8'h00
`define SADC_CTRL2_RESET    8'h00
`define SADC_BIT_ENABLE     0
`define SADC_BIT_GO         1
`define SADC_BIT_JUSTIFY    7
`define SADC_CONV_TADS      4'd11
`define SADC_GAP_TADS       4'd2
`define SADC_CLK_PERIOD_NS  10
`define SADC_RC_TAD_NS      4000
`define SADC_RC_DIV         (`SADC_RC_TAD_NS / `SADC_CLK_PERIOD_NS)
`define SADC_FULL_SCALE     10'h3ff
`endif

// >>> shared/sadc_pkg.sv
// Types for the converter sequencer
package sadc_pkg;
    typedef enum logic [3:0] {
        SADC_IDLE = 4'b0001,
        SADC_ACQ  = 4'b0010,
        SADC_CONV = 4'b0100,
        SADC_GAP  = 4'b1000
    } sadc_state_t;

    typedef struct packed {
        logic [2:0] ch;
        logic       go;
        logic       en;
    } sadc_ctrl0_t;

    typedef struct packed {
        logic       justify;
        logic [2:0] acq;
        logic [2:0] clk;
    } sadc_ctrl2_t;

    typedef struct packed {
        sadc_state_t  st;
        sadc_ctrl0_t  c0;
        logic [6:0]   pcfg;
        sadc_ctrl2_t  c2;
        logic         done_flag;
        logic [11:0]  div;
        logic         conversion_bit_period;
        logic [4:0]   tcnt;
        logic         delay;
        logic [9:0]   sar;
        logic         ap_valid;
        logic         ap_write;
        logic [7:0]   ap_addr;
        logic [31:0]  rdata;
        logic [6:0]   pin_meta;
        logic [6:0]   pin_sync;
    } sadc_state_vec_t;
endpackage

// >>> sim/sadc_analog_model.sv
// Analog pins and comparator on the far side of the sequencer
`timescale 1ns/1ps
module sadc_analog_model (
    input  wire logic [6:0]  channel_route,
    input  wire logic [9:0]  dac_code,
    input  wire logic [69:0] level,
    output logic             comparator_in
);
    // Level at or above trial code; nothing routed reads low
    always_comb begin
        comparator_in = 1'b0;
        for (int i = 0; i < 7; i++) begin
            if (channel_route[i] && level[i*10 +: 10] >= dac_code) begin
                comparator_in = 1'b1;
            end
        end
    end
endmodule

// >>> sim/sadc_sequencer_assertions.sv
// Port assertions for the converter sequencer
`timescale 1ns/1ps
module sadc_seq_assertions (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic [6:0] channel_route,
    input wire logic       sample_enable,
    input wire logic [6:0] pin_digital_value,
    input wire logic [6:0] pin_analog_mode,
    input wire logic       conversion_done_flag,
    input wire logic       converter_enable
);
    logic [15:0] cnt_r;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Cycles since sampling stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= sample_enable ? 16'h0000 : cnt_r + 16'h0001;
        end
    end
    property p_bus; hreadyout && !hresp; endproperty
    a_bus: assert property (p_bus) else $error("bus answer");
    property p_route; $onehot0(channel_route); endproperty
    a_route: assert property (p_route) else $error("route");
    property p_off; !converter_enable |-> channel_route == 7'h00 && !sample_enable; endproperty
    a_off: assert property (p_off) else $error("disabled");
    property p_pin; (pin_digital_value & pin_analog_mode) == 7'h00; endproperty
    a_pin: assert property (p_pin) else $error("analog pin");
    property p_conv; $rose(conversion_done_flag) |-> cnt_r >= 16'd22; endproperty
    a_conv: assert property (p_conv) else $error("short conversion");
    property p_gap; $rose(conversion_done_flag) |-> !sample_enable [*3]; endproperty
    a_gap: assert property (p_gap) else $error("gap");
    property p_resume; $rose(conversion_done_flag) && converter_enable |-> ##[1:1000] sample_enable; endproperty
    a_resume: assert property (p_resume) else $error("resume");
    property p_rst; $rose(hresetn) |-> !converter_enable && !conversion_done_flag && !sample_enable; endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule
bind sadc_sequencer sadc_seq_assertions u_chk (.hclk, .hresetn, .hreadyout, .hresp, .channel_route,
    .sample_enable, .pin_digital_value, .pin_analog_mode, .conversion_done_flag, .converter_enable);

// >>> sim/tb_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_sar_adc_sequencer;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd, v, seed = 32'h1b;
    logic        hreadyout, hresp, comparator_in, sample_enable, conversion_done_flag, converter_enable;
    logic [6:0]  pin_digital_in = 7'h00, pin_digital_value, pin_analog_mode, channel_route;
    logic [9:0]  dac_code;
    logic [69:0] level = 70'h0;
    logic [95:0] lv;
    int          errors = 0, checked = 0, conversion_bit_period, ex, n;
    always #5 hclk = ~hclk;
    sadc_sequencer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .comparator_in, .pin_digital_in, .pin_digital_value, .pin_analog_mode,
        .channel_route, .sample_enable, .dac_code, .conversion_done_flag, .converter_enable);
    sadc_analog_model u_ana (.channel_route, .dac_code, .level, .comparator_in);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        checked++;
        if (got !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic test_done();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hsize <= 3'b010;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b1, 8'h18, 32'hffff_ffff);
        for (int a = 0; a < 28; a += 4) begin
            if (a != 12 && a != 16) rc(8'(a), 32'h0);
        end
        v = rnd();
        pin_digital_in <= v[14:8];
        bus(1'b1, 8'h04, {25'h0, v[6:0]});
        repeat (4) @(posedge hclk);
        chk(pin_digital_value, pin_digital_in & v[6:0]);
        chk(pin_analog_mode, 7'(~v[6:0]));
        for (int k = 0; k < 8; k++) begin
            lv = {rnd(), rnd(), rnd()};
            level <= lv[69:0];
            conversion_bit_period = k[1:0] == 2'b11 ? 400 : 2 << (2 * k[1:0] + k[2]);
            bus(1'b1, 8'h14, 32'h0);
            bus(1'b1, 8'h08, {24'h0, k[0], 1'b0, 3'(k), 3'(k)});
            bus(1'b1, 8'h00, {27'h0, 3'(k), 2'b01});
            bus(1'b1, 8'h00, {27'h0, 3'(k), 2'b11});
            rc(8'h00, {27'h0, 3'(k), 2'b11});
            n = 2;
            while (conversion_done_flag !== 1'b1 && n < 20000) begin
                @(posedge hclk);
                n++;
            end
            ex = ((k < 5 ? 2 * k : 4 * k - 8) + 11) * conversion_bit_period + (k == 0);
            chk(32'(n >= ex - conversion_bit_period && n <= ex + conversion_bit_period + 8), 32'h1);
            rc(8'h00, {27'h0, 3'(k), 2'b01});
            rc(8'h14, 32'h1);
            ex = k == 7 ? 1023 : int'(lv[k*10 +: 10]);
            rc(8'h0c, k[0] ? ex >> 8 : ex >> 2);
            rc(8'h10, k[0] ? ex & 255 : (ex & 3) << 6);
            repeat (2 * conversion_bit_period + 4) @(posedge hclk);
            chk({sample_enable, channel_route}, k == 7 ? 8'h80 : 8'h80 | 8'(1 << k));
        end
        // Abort by clearing go, then by reset
        bus(1'b1, 8'h14, 32'h0);
        bus(1'b1, 8'h08, 32'h6);
        bus(1'b1, 8'h00, 32'h3);
        repeat (100) @(posedge hclk);
        bus(1'b1, 8'h00, 32'h1);
        repeat (800) @(posedge hclk);
        rc(8'h14, 32'h0);
        bus(1'b1, 8'h00, 32'h3);
        repeat (100) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(8'h00, 32'h0);
        // Last completed result is full scale; justify is back to left after reset
        rc(8'h0c, 32'hff);
        rc(8'h10, 32'hc0);
        test_done();
    end
    initial begin
        repeat (60000) @(posedge hclk);
        errors++;
        test_done();
    end
endmodule
